/* inc/wdt_cgc_defines.svh */
// constants for the watchdog and clock generator control block
`ifndef WDT_CGC_DEFINES_SVH
`define WDT_CGC_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_MODE_OFFSET 5'h00
`define REG_COMMAND_OFFSET 5'h04
`define REG_STATUS_OFFSET 5'h08
`define REG_MASK_OFFSET 5'h0C
`define REG_STATE_OFFSET 5'h10
`define REG_CONFIG_OFFSET 5'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MODE_WDT_ENABLE_BIT 0
`define MODE_PERIOD_LSB 1
`define MODE_PERIOD_MSB 2
`define MODE_FAULT_TO_RESET_BIT 3
`define MODE_DIV_BYPASS_BIT 4
`define MODE_PD_LSB 5
`define MODE_PD_MSB 6
`define CMD_WDT_CLEAR_BIT 0
`define CFG_EXT_CLOCK_BIT 0
`define CFG_ENHANCED_BIT 1
`define EVT_TIMEOUT_BIT 0
`define EVT_PD_ENTRY_BIT 1
`define EVT_WAKE_BIT 2
`define EVT_WIDTH 3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MODE_RESET 7'h09
`define CONFIG_RESET 2'h2
`define MASK_RESET 3'h0

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define WDT_PULSE_CYCLES 3'h5
`define WDT_PERIOD_BASE_CYCLES 24'h010000

`endif

/* inc/wdt_cgc_pkg.sv */
// types for the watchdog and clock generator control block
package wdt_cgc_pkg;

  typedef enum logic [1:0] {
    PD_RUN,
    PD_FIRST_IDLE_MODE,
    PD_SECOND_IDLE_MODE,
    PD_STOP
  } pd_mode_t;

endpackage

/* sim/sys_partner.sv */
// crystal source and pulled-up reset line around the block
`timescale 1ns/1ps
`default_nettype none
module sys_partner (
  input wire logic i_clk,
  input wire logic [2:0] i_half,
  input wire logic i_pin_low,
  output logic o_crystal,
  output logic o_reset_pin_n
);
  logic [2:0] cnt_ff = 3'h0;
  logic osc_ff = 1'b0;
  wire logic flip = cnt_ff >= i_half - 3'h1;
  // oscillator runs free; half period of 3 or more keeps it slow enough
  always @(posedge i_clk) begin
    cnt_ff <= flip ? 3'h0 : cnt_ff + 3'h1;
    if (flip) osc_ff <= !osc_ff;
  end
  assign o_crystal = osc_ff;
  // open-drain line: pull-up wins unless someone pulls low
  assign o_reset_pin_n = !i_pin_low;
endmodule // sys_partner
`default_nettype wire

/* sim/watchdog_and_clock_gen_control_tb.sv */
// self-checking bench for the watchdog and clock control block
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_clock_gen_control_tb;
  // short period keeps the run small; the timeout checks derive from it
  localparam logic [23:0] BASE = 24'h000010;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic halt = 1'b0, wake = 1'b0, pin_low = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, rng = 32'h0001562F;
  logic [3:0] be = 4'hF;
  logic [2:0] half = 3'h3;
  logic wait_q, xin, xo, gclk, pin_n, fault_n, cpu_en, tmr_en, irq;
  int err_total = 0, comparisons = 0, cyc = 0;
  wdt_cgc_top #(.WDT_PERIOD_BASE(BASE)) i_wdt_cgc_top (.I_CLOCK(clk),
    .I_RST_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_q),
    .I_CRYSTAL_TERMINAL_IN(xin), .O_CRYSTAL_TERMINAL_OUT(xo),
    .O_GENERATOR_CLOCK_OUTPUT(gclk), .I_RESET_PIN_N(pin_n), .I_HALT(halt),
    .I_WAKE(wake), .O_WATCHDOG_FAULT_N(fault_n), .O_CPU_CLOCK_EN(cpu_en),
    .O_PARALLEL_PORT_CLOCK_EN(), .O_SERIAL_IO_CLOCK_EN(),
    .O_COUNTER_TIMER_CLOCK_EN(tmr_en), .O_IRQ(irq));
  sys_partner i_sys_partner (.i_clk(clk), .i_half(half),
    .i_pin_low(pin_low), .o_crystal(xin), .o_reset_pin_n(pin_n));
  initial forever #2 clk = ~clk;
  // ------
  // helpers
  // ------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int per(input logic [1:0] s);
    return int'(BASE) << (2 * s);
  endfunction
  function automatic logic ok(input logic [1:0] c, input logic [1:0] p);
    return p != 2'h0 && (!c[0] || (c[1] && p == 2'h2));
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    // waitrequest and read data are taken at the completing rising edge
    do @(posedge clk); while (wait_q !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wrr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rdc(input string n, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(n, q, e);
  endtask
  task automatic pls(input logic h);
    @(posedge clk);
    halt <= h;
    wake <= !h;
    @(posedge clk);
    halt <= 1'b0;
    wake <= 1'b0;
  endtask
  task automatic till(input logic v, input int mx, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (fault_n !== v && n < mx);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ------
  // scenarios
  // ------
  initial begin
    logic [31:0] q, m;
    logic [1:0] c, p;
    int n, s, a, g, e, b;
    logic px, pg, po;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc("mode reset", 5'h00, 32'h09);
    till(1'b0, 200, n);
    chk("timeout", 32'(n >= per(0) - 8 && n <= per(0) + 4), 1);
    till(1'b1, 20, n);
    chk("pulse width", 32'(n), 32'h5);
    rdc("timeout flag", 5'h08, 32'h1);
    wrr(5'h00, 32'h08);
    till(1'b0, 100, n);
    chk("disabled", 32'(n), 32'd100);
    chk("irq masked", 32'(irq), 32'h0);
    wrr(5'h0C, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq set", 32'(irq), 32'h1);
    wrr(5'h08, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq clear", 32'(irq), 32'h0);
    $display("test pulse done");
    wrr(5'h00, 32'h01);
    till(1'b0, 200, n);
    repeat (40) @(negedge clk);
    chk("held low", 32'(fault_n), 32'h0);
    rdc("state held", 5'h10, 32'h1);
    wrr(5'h04, 32'h1);
    till(1'b1, 4, n);
    chk("clear release", 32'(n <= 3), 32'h1);
    till(1'b0, 200, n);
    chk("restart", 32'(n >= per(0) - 4 && n <= per(0) + 4), 32'h1);
    @(posedge clk) pin_low <= 1'b1;
    repeat (4) @(posedge clk);
    pin_low <= 1'b0;
    @(negedge clk);
    chk("pin release", 32'(fault_n), 32'h1);
    $display("test held done");
    wrr(5'h00, 32'h43);
    wrr(5'h04, 32'h1);
    repeat (20) @(posedge clk);
    pls(1'b1);
    @(negedge clk);
    chk("idle run", 32'({cpu_en, tmr_en}), 32'h1);
    repeat (150) @(negedge clk);
    chk("frozen", 32'(fault_n), 32'h1);
    rdc("state idle", 5'h10, 32'h8);
    pls(1'b0);
    till(1'b0, 200, n);
    chk("resume", 32'(n >= per(1) - 28 && n <= per(1) - 14), 32'h1);
    wrr(5'h04, 32'h1);
    $display("test freeze done");
    // the two long period selects, one of them drawn at random
    rng = xs(rng);
    p = {1'b1, rng[0]};
    wrr(5'h00, {25'h0, 4'h1, p, 1'b1});
    wrr(5'h04, 32'h1);
    till(1'b0, 1100, n);
    chk("long", 32'(n >= per(p) - 4 && n <= per(p) + 4), 32'h1);
    till(1'b1, 20, n);
    chk("long pulse", 32'(n), 32'h5);
    $display("test period done");
    for (s = 0; s < 16; s++) begin
      c = s[3:2];
      p = s[1:0];
      wrr(5'h14, {30'h0, c});
      wrr(5'h00, {25'h0, p, 5'h08});
      pls(1'b1);
      @(negedge clk);
      chk("halt", 32'(cpu_en), 32'(!ok(c, p)));
      chk("timer", 32'(tmr_en), 32'(!ok(c, p) || p == 2'h2));
      if (p == 2'h3 && ok(c, p)) begin
        g = 0;
        repeat (16) begin
          @(negedge clk);
          g += int'(gclk);
        end
        chk("stop gen", 32'(g), 32'h0);
      end
      pls(1'b0);
      @(negedge clk);
      chk("wake", 32'(cpu_en), 32'h1);
    end
    rdc("events", 5'h08, 32'h7);
    wrr(5'h08, 32'h7);
    $display("test power-down done");
    for (s = 0; s < 3; s++) begin
      rng = xs(rng);
      @(posedge clk) half <= 3'h3 + {1'b0, rng[1:0]};
      wrr(5'h14, s == 2 ? 32'h3 : 32'h2);
      wrr(5'h00, s > 0 ? 32'h18 : 32'h08);
      repeat (20) @(negedge clk);
      a = 0;
      g = 0;
      b = 0;
      repeat (600) begin
        px = xin;
        pg = gclk;
        po = xo;
        @(negedge clk);
        a += int'(xin & !px);
        g += int'(gclk & !pg);
        b += int'(po & !xo);
      end
      e = s == 1 ? a : a / 2;
      chk("gen", 32'(g >= e - 1 && g <= e + 1), 32'h1);
      chk("crystal out", 32'(b >= a - 1 && b <= a + 1), 32'h1);
    end
    wrr(5'h14, 32'h2);
    $display("test generator done");
    // mask still holds the one written by the interrupt test
    m = 32'h1;
    for (s = 0; s < 6; s++) begin
      rng = xs(rng);
      bus(1'b1, 5'h0C, rng, 4'hE, q);
      rdc("lane off", 5'h0C, m);
      wrr(5'h0C, rng);
      m = {29'h0, rng[2:0]};
      rdc("mask", 5'h0C, m);
      rdc("unmapped", {2'h3, rng[2:0]}, 32'h0);
    end
    $display("test bus done");
    report_and_stop();
  end
endmodule // watchdog_and_clock_gen_control_tb
`default_nettype wire

/* sim/watchdog_ctl_checker.sv */
// port assertions for the watchdog and clock control block
`timescale 1ns/1ps
`default_nettype none
module watchdog_ctl_checker #(
  parameter logic [23:0] WDT_PERIOD_BASE = 24'h010000
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_RESET_PIN_N,
  input wire logic I_HALT,
  input wire logic O_WATCHDOG_FAULT_N,
  input wire logic O_CPU_CLOCK_EN,
  input wire logic O_PARALLEL_PORT_CLOCK_EN,
  input wire logic O_SERIAL_IO_CLOCK_EN,
  input wire logic O_COUNTER_TIMER_CLOCK_EN
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  // ------
  // shadow of mode and config, and a live count of the period
  // ------
  logic [6:0] mode_ff;
  logic [1:0] cfg_ff;
  logic [2:0] quiet_ff;
  logic [31:0] live_ff;
  wire logic wr_done = I_AVS_WRITE && !O_AVS_WAITREQUEST
    && I_AVS_BYTEENABLE[0];
  wire logic [31:0] per = {8'h00, WDT_PERIOD_BASE} << {mode_ff[2:1], 1'b0};
  wire logic [1:0] pd = mode_ff[6:5];
  wire logic pd_ok = pd != 2'h0
    && (!cfg_ff[0] || (cfg_ff[1] && pd == 2'h2));
  // any write or pin reset restarts the shadow count: only errs late
  wire logic hush = I_AVS_WRITE || !I_RESET_PIN_N;
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      mode_ff <= 7'h09;
      cfg_ff <= 2'h2;
      quiet_ff <= 3'h0;
      live_ff <= 32'h0;
    end else begin
      if (wr_done && I_AVS_ADDRESS == 5'h00) mode_ff <= I_AVS_WRITEDATA[6:0];
      if (wr_done && I_AVS_ADDRESS == 5'h14) cfg_ff <= I_AVS_WRITEDATA[1:0];
      quiet_ff <= hush ? 3'h0 : quiet_ff + 3'(quiet_ff != 3'h7);
      if (hush || !O_WATCHDOG_FAULT_N || !mode_ff[0]) live_ff <= 32'h0;
      else if (O_CPU_CLOCK_EN) live_ff <= live_ff + 32'h1;
    end
  end
  pulse_width_a: assert property ($fell(O_WATCHDOG_FAULT_N)
    && mode_ff[3] |-> !O_WATCHDOG_FAULT_N [*5] ##1 O_WATCHDOG_FAULT_N)
    else $error("fault pulse not five cycles");
  fault_hold_a: assert property (!O_WATCHDOG_FAULT_N && !mode_ff[3]
    && quiet_ff > 3'h3 |=> !O_WATCHDOG_FAULT_N)
    else $error("held fault released early");
  period_late_a: assert property (live_ff <= per + 32'h8)
    else $error("watchdog timeout missing");
  bus_answer_a: assert property ((I_AVS_READ || I_AVS_WRITE)
    && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
    else $error("bus answer timing wrong");
  enables_tied_a: assert property (O_CPU_CLOCK_EN
    == O_SERIAL_IO_CLOCK_EN && O_CPU_CLOCK_EN == O_PARALLEL_PORT_CLOCK_EN)
    else $error("run clock enables differ");
  timer_run_a: assert property (O_CPU_CLOCK_EN
    |-> O_COUNTER_TIMER_CLOCK_EN)
    else $error("timer clock off in run");
  timer_idle_a: assert property ($fell(O_CPU_CLOCK_EN)
    |-> O_COUNTER_TIMER_CLOCK_EN == (pd == 2'h2))
    else $error("timer clock wrong in power-down");
  halt_entry_a: assert property (I_HALT && O_CPU_CLOCK_EN
    && pd_ok |=> !O_CPU_CLOCK_EN)
    else $error("allowed halt not taken");
  halt_refused_a: assert property (I_HALT && O_CPU_CLOCK_EN
    && !pd_ok |=> O_CPU_CLOCK_EN)
    else $error("forbidden halt taken");
  cover property ($fell(O_WATCHDOG_FAULT_N) && mode_ff[3]);
  cover property (!O_WATCHDOG_FAULT_N && quiet_ff == 3'h7);
  cover property (!O_CPU_CLOCK_EN && O_COUNTER_TIMER_CLOCK_EN);
endmodule // watchdog_ctl_checker
bind wdt_cgc_top watchdog_ctl_checker #(.WDT_PERIOD_BASE(WDT_PERIOD_BASE))
  i_watchdog_ctl_checker (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .I_RESET_PIN_N(I_RESET_PIN_N), .I_HALT(I_HALT),
  .O_WATCHDOG_FAULT_N(O_WATCHDOG_FAULT_N), .O_CPU_CLOCK_EN(O_CPU_CLOCK_EN),
  .O_PARALLEL_PORT_CLOCK_EN(O_PARALLEL_PORT_CLOCK_EN),
  .O_SERIAL_IO_CLOCK_EN(O_SERIAL_IO_CLOCK_EN),
  .O_COUNTER_TIMER_CLOCK_EN(O_COUNTER_TIMER_CLOCK_EN));
`default_nettype wire

/* src/clock_gen_unit.sv */
// clock generator: samples the crystal terminal, divides or bypasses
`timescale 1ns/1ps
`default_nettype none

module clock_gen_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_crystal_in,
  input wire logic i_bypass,
  input wire logic i_ext_clock,
  input wire logic i_stop_osc,
  output logic o_gen_clock,
  output logic o_crystal_out
);

  logic xtal_meta_ff;
  logic xtal_sync_ff;
  logic xtal_prev_ff;
  logic gen_ff;
  logic xout_ff;
  logic rising;
  logic bypass_eff;

  // sampled at the system rate: input must stay well below a quarter of it
  assign rising = xtal_sync_ff & ~xtal_prev_ff;
  assign bypass_eff = i_bypass & ~i_ext_clock;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      xtal_meta_ff <= 1'b0;
      xtal_sync_ff <= 1'b0;
      xtal_prev_ff <= 1'b0;
      gen_ff <= 1'b0;
      xout_ff <= 1'b1;
    end else begin
      xtal_meta_ff <= i_crystal_in;
      xtal_sync_ff <= xtal_meta_ff;
      xtal_prev_ff <= xtal_sync_ff;
      if (i_stop_osc) begin
        gen_ff <= 1'b0;
      end else if (bypass_eff) begin
        gen_ff <= xtal_sync_ff;
      end else if (rising) begin
        gen_ff <= ~gen_ff;
      end
      if (!i_stop_osc) begin
        xout_ff <= ~xtal_sync_ff;
      end
    end
  end

  assign o_gen_clock = gen_ff;
  assign o_crystal_out = xout_ff;

endmodule // clock_gen_unit

`default_nettype wire

/* src/wdt_cgc_top.sv */
// watchdog and clock generator / power-down control, Avalon-MM slave
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cgc_defines.svh"

module wdt_cgc_top #(
  parameter logic [23:0] WDT_PERIOD_BASE = `WDT_PERIOD_BASE_CYCLES
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_CRYSTAL_TERMINAL_IN,
  output logic O_CRYSTAL_TERMINAL_OUT,
  output logic O_GENERATOR_CLOCK_OUTPUT,
  input wire logic I_RESET_PIN_N,
  input wire logic I_HALT,
  input wire logic I_WAKE,
  output logic O_WATCHDOG_FAULT_N,
  output logic O_CPU_CLOCK_EN,
  output logic O_PARALLEL_PORT_CLOCK_EN,
  output logic O_SERIAL_IO_CLOCK_EN,
  output logic O_COUNTER_TIMER_CLOCK_EN,
  output logic O_IRQ
);

  // --------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------
  logic [6:0] mode_ff;
  logic [1:0] config_ff;
  logic [2:0] status_ff;
  logic [2:0] mask_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic clear_ff;
  logic rstpin_meta_ff;
  logic rstpin_sync_ff;
  wdt_cgc_pkg::pd_mode_t pd_ff;
  wdt_cgc_pkg::pd_mode_t nxt_pd;
  logic cpu_en_ff;
  logic pio_en_ff;
  logic sio_en_ff;
  logic ctc_en_ff;

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  logic req;
  logic wr_take;
  logic rd_prep;
  logic lane0;
  logic sel_mode;
  logic sel_cmd;
  logic sel_status;
  logic sel_mask;
  logic sel_state;
  logic sel_config;
  logic wr_mode;
  logic wr_status;
  logic wr_mask;
  logic wr_config;
  logic wr_clear;
  logic [31:0] rd_mux;

  assign req = I_AVS_READ | I_AVS_WRITE;
  // first cycle of a request prepares data, second completes it
  assign rd_prep = req & wait_ff;
  assign wr_take = I_AVS_WRITE & ~wait_ff;
  assign lane0 = I_AVS_BYTEENABLE[0];
  assign sel_mode = I_AVS_ADDRESS == `REG_MODE_OFFSET;
  assign sel_cmd = I_AVS_ADDRESS == `REG_COMMAND_OFFSET;
  assign sel_status = I_AVS_ADDRESS == `REG_STATUS_OFFSET;
  assign sel_mask = I_AVS_ADDRESS == `REG_MASK_OFFSET;
  assign sel_state = I_AVS_ADDRESS == `REG_STATE_OFFSET;
  assign sel_config = I_AVS_ADDRESS == `REG_CONFIG_OFFSET;
  assign wr_mode = wr_take & lane0 & sel_mode;
  assign wr_status = wr_take & lane0 & sel_status;
  assign wr_mask = wr_take & lane0 & sel_mask;
  assign wr_config = wr_take & lane0 & sel_config;
  assign wr_clear = wr_take & lane0 & sel_cmd &
                    I_AVS_WRITEDATA[`CMD_WDT_CLEAR_BIT];

  // --------------------------------------------------------------------
  // sub-units
  // --------------------------------------------------------------------
  logic ext_reset;
  logic wdt_halted;
  logic stop_osc;
  logic wdt_fault_n;
  logic wdt_timeout;
  logic wdt_counting;
  logic gen_clock;
  logic crystal_out;

  assign ext_reset = ~rstpin_sync_ff;
  assign wdt_halted = pd_ff != wdt_cgc_pkg::PD_RUN;
  assign stop_osc = pd_ff == wdt_cgc_pkg::PD_STOP;

  wdt_counter #(
    .PERIOD_BASE(WDT_PERIOD_BASE)
  ) u_wdt (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_enable(mode_ff[`MODE_WDT_ENABLE_BIT]),
    .i_halted(wdt_halted),
    .i_clear(clear_ff),
    .i_ext_reset(ext_reset),
    .i_fault_to_reset(mode_ff[`MODE_FAULT_TO_RESET_BIT]),
    .i_period_sel(mode_ff[`MODE_PERIOD_MSB:`MODE_PERIOD_LSB]),
    .o_fault_n(wdt_fault_n),
    .o_timeout(wdt_timeout),
    .o_counting(wdt_counting)
  );

  clock_gen_unit u_cgc (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_crystal_in(I_CRYSTAL_TERMINAL_IN),
    .i_bypass(mode_ff[`MODE_DIV_BYPASS_BIT]),
    .i_ext_clock(config_ff[`CFG_EXT_CLOCK_BIT]),
    .i_stop_osc(stop_osc),
    .o_gen_clock(gen_clock),
    .o_crystal_out(crystal_out)
  );

  // --------------------------------------------------------------------
  // power-down mode control
  // --------------------------------------------------------------------
  wdt_cgc_pkg::pd_mode_t pd_req;
  logic ext_clk;
  logic enhanced;
  logic pd_allowed;
  logic pd_enter;
  logic pd_leave;

  assign pd_req = wdt_cgc_pkg::pd_mode_t'(mode_ff[`MODE_PD_MSB:`MODE_PD_LSB]);
  assign ext_clk = config_ff[`CFG_EXT_CLOCK_BIT];
  assign enhanced = config_ff[`CFG_ENHANCED_BIT];
  // refused halts simply keep the part running
  assign pd_allowed = ~ext_clk |
                      (enhanced & (pd_req == wdt_cgc_pkg::PD_SECOND_IDLE_MODE));
  assign pd_enter = (pd_ff == wdt_cgc_pkg::PD_RUN) & I_HALT & pd_allowed &
                    (pd_req != wdt_cgc_pkg::PD_RUN);
  assign pd_leave = (pd_ff != wdt_cgc_pkg::PD_RUN) & (I_WAKE | ext_reset);

  always_comb begin
    nxt_pd = pd_ff;
    case (pd_ff)
      wdt_cgc_pkg::PD_RUN: begin
        if (pd_enter) begin
          nxt_pd = pd_req;
        end
      end
      wdt_cgc_pkg::PD_FIRST_IDLE_MODE,
      wdt_cgc_pkg::PD_SECOND_IDLE_MODE,
      wdt_cgc_pkg::PD_STOP: begin
        if (pd_leave) begin
          nxt_pd = wdt_cgc_pkg::PD_RUN;
        end
      end
      default: begin
        nxt_pd = wdt_cgc_pkg::PD_RUN;
      end
    endcase
  end

  logic nxt_run;
  logic nxt_ctc;

  assign nxt_run = nxt_pd == wdt_cgc_pkg::PD_RUN;
  assign nxt_ctc = nxt_run | (nxt_pd == wdt_cgc_pkg::PD_SECOND_IDLE_MODE);

  // --------------------------------------------------------------------
  // events and interrupt
  // --------------------------------------------------------------------
  logic [2:0] evt;
  logic [2:0] clr_bits;
  logic [2:0] nxt_status;

  assign evt = {pd_leave, pd_enter, wdt_timeout};
  assign clr_bits = wr_status ? I_AVS_WRITEDATA[2:0] : 3'h0;
  // set wins over a same-cycle write-one-to-clear
  assign nxt_status = (status_ff & ~clr_bits) | evt;

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  logic [31:0] state_word;

  assign state_word = {28'h0000000, pd_ff, wdt_counting, ~wdt_fault_n};
  assign rd_mux = sel_mode ? {25'h0000000, mode_ff} :
                  sel_status ? {29'h00000000, status_ff} :
                  sel_mask ? {29'h00000000, mask_ff} :
                  sel_state ? state_word :
                  sel_config ? {30'h00000000, config_ff} :
                  32'h00000000;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= ~rd_prep;
      if (rd_prep) begin
        rdata_ff <= I_AVS_READ ? rd_mux : 32'h00000000;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      mode_ff <= `MODE_RESET;
      config_ff <= `CONFIG_RESET;
      mask_ff <= `MASK_RESET;
    end else begin
      if (wr_mode) begin
        mode_ff <= I_AVS_WRITEDATA[6:0];
      end
      if (wr_config) begin
        config_ff <= I_AVS_WRITEDATA[1:0];
      end
      if (wr_mask) begin
        mask_ff <= I_AVS_WRITEDATA[2:0];
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      status_ff <= 3'h0;
      irq_ff <= 1'b0;
      clear_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & mask_ff);
      clear_ff <= wr_clear;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      rstpin_meta_ff <= 1'b1;
      rstpin_sync_ff <= 1'b1;
    end else begin
      rstpin_meta_ff <= I_RESET_PIN_N;
      rstpin_sync_ff <= rstpin_meta_ff;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      pd_ff <= wdt_cgc_pkg::PD_RUN;
      cpu_en_ff <= 1'b1;
      pio_en_ff <= 1'b1;
      sio_en_ff <= 1'b1;
      ctc_en_ff <= 1'b1;
    end else begin
      pd_ff <= nxt_pd;
      cpu_en_ff <= nxt_run;
      pio_en_ff <= nxt_run;
      sio_en_ff <= nxt_run;
      ctc_en_ff <= nxt_ctc;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign O_AVS_READDATA = rdata_ff;
  assign O_AVS_WAITREQUEST = wait_ff;
  assign O_IRQ = irq_ff;
  assign O_WATCHDOG_FAULT_N = wdt_fault_n;
  // generator output is never used internally
  assign O_GENERATOR_CLOCK_OUTPUT = gen_clock;
  assign O_CRYSTAL_TERMINAL_OUT = crystal_out;
  assign O_CPU_CLOCK_EN = cpu_en_ff;
  assign O_PARALLEL_PORT_CLOCK_EN = pio_en_ff;
  assign O_SERIAL_IO_CLOCK_EN = sio_en_ff;
  assign O_COUNTER_TIMER_CLOCK_EN = ctc_en_ff;

endmodule // wdt_cgc_top

`default_nettype wire

/* src/wdt_counter.sv */
// watchdog timeout counter and fault output shaping
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cgc_defines.svh"

module wdt_counter #(
  parameter logic [23:0] PERIOD_BASE = `WDT_PERIOD_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_halted,
  input wire logic i_clear,
  input wire logic i_ext_reset,
  input wire logic i_fault_to_reset,
  input wire logic [1:0] i_period_sel,
  output logic o_fault_n,
  output logic o_timeout,
  output logic o_counting
);

  logic [23:0] cnt_ff;
  logic [2:0] pulse_ff;
  logic fault_n_ff;
  logic timeout_ff;
  logic [23:0] limit;
  logic release_all;
  logic active;
  logic expire;

  // period grows by four per select step
  assign limit = PERIOD_BASE << {i_period_sel, 1'b0};
  assign release_all = i_clear | i_ext_reset | ~i_enable;
  assign active = i_enable & ~i_halted & fault_n_ff;
  assign expire = active & (cnt_ff == limit - 24'h000001);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_ff <= 24'h000000;
      pulse_ff <= 3'h0;
      fault_n_ff <= 1'b1;
      timeout_ff <= 1'b0;
    end else begin
      timeout_ff <= expire & ~release_all;
      if (release_all) begin
        cnt_ff <= 24'h000000;
        fault_n_ff <= 1'b1;
        pulse_ff <= 3'h0;
      end else if (expire) begin
        cnt_ff <= 24'h000000;
        fault_n_ff <= 1'b0;
        pulse_ff <= `WDT_PULSE_CYCLES - 3'h1;
      end else if (!fault_n_ff) begin
        // pulse mode ends by itself; held mode waits for a clear, a pin reset or a disable
        if (i_fault_to_reset) begin
          if (pulse_ff == 3'h0) begin
            fault_n_ff <= 1'b1;
          end else begin
            pulse_ff <= pulse_ff - 3'h1;
          end
        end
      end else if (active) begin
        cnt_ff <= cnt_ff + 24'h000001;
      end
    end
  end

  assign o_fault_n = fault_n_ff;
  assign o_timeout = timeout_ff;
  assign o_counting = active;

endmodule // wdt_counter

`default_nettype wire
